// >>> ppo_alt_model.sv
// model of the peripherals owning alternate pin functions
// assumes requests from the bench on ref_clk; one cycle to reach the port
`timescale 1ns/1ns
module ppo_alt_model #(
  parameter int NPINS = 8,
  parameter logic [7:0] ALT_PRESENT = 8'hFF
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire ppo_pkg::ppo_ovr_t [NPINS-1:0] req_ovr,
  input wire logic [NPINS-1:0] req_an_out,
  input wire logic [NPINS-1:0] req_an_oe,
  input wire logic [NPINS-1:0] raw_digital_in,
  output ppo_pkg::ppo_ovr_t [NPINS-1:0] alt_ovr,
  output logic [NPINS-1:0] an_out,
  output logic [NPINS-1:0] an_oe,
  output logic [NPINS-1:0] di_sync
);
  ppo_pkg::ppo_ovr_t [NPINS-1:0] ovr_ff;
  logic [NPINS-1:0] an_out_ff;
  logic [NPINS-1:0] an_oe_ff;
  logic [NPINS-1:0] meta_ff;
  logic [NPINS-1:0] sync_ff;

  assign alt_ovr = ovr_ff;
  assign an_out = an_out_ff;
  assign an_oe = an_oe_ff;
  assign di_sync = sync_ff;

  // own override bundles; pins without a function stay low
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ovr_ff <= '0;
    end else begin
      for (int i = 0; i < NPINS; i++) begin
        ovr_ff[i] <= ALT_PRESENT[i] ? req_ovr[i] : '0;
      end
    end
  end

  // analog drive; released line wanders instead of holding its value
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      an_out_ff <= '0;
      an_oe_ff <= '0;
    end else begin
      an_oe_ff <= req_an_oe;
      an_out_ff <= (req_an_oe & req_an_out) | (~req_an_oe & ~an_out_ff);
    end
  end

  // own synchroniser for the raw input
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= raw_digital_in;
      sync_ff <= meta_ff;
    end
  end
endmodule

// >>> ppo_pin_cell.sv
// override logic of one pin: pull-up, driver enable, value, input enable
// assumes register bits and overrides come from ref_clk logic
`timescale 1ns/1ns
module ppo_pin_cell (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic dir_bit,
  input wire logic outval_bit,
  input wire logic global_pullup_disable,
  input wire logic sleep_clamp,
  input wire logic ext_int_active,
  input wire ppo_pkg::ppo_ovr_t ovr,
  output logic input_en,
  output ppo_pkg::ppo_pad_t pad
);

  ppo_pkg::ppo_pad_t pad_ff;
  ppo_pkg::ppo_pad_t nxt_pad;

  // digital input enable with sleep clamp and overrides
  always_comb begin
    if (ovr.input_en_override_en) begin
      input_en = ovr.input_en_override_val;
    end else begin
      input_en = !(sleep_clamp && !ext_int_active);
    end
  end

  // next pad drive from register bits and overrides
  always_comb begin
    nxt_pad = '0;
    if (ovr.dir_override_en) begin
      nxt_pad.oe = ovr.dir_override_val;
    end else begin
      nxt_pad.oe = dir_bit;
    end
    if (ovr.value_override_en) begin
      nxt_pad.out = ovr.value_override_val;
    end else begin
      nxt_pad.out = outval_bit;
    end
    if (ovr.pullup_override_en) begin
      nxt_pad.pullup_en = ovr.pullup_override_val;
    end else begin
      nxt_pad.pullup_en = ({dir_bit, outval_bit, global_pullup_disable} == 3'b010);
    end
  end

  // pad drive register, tri-stated without pull-up during reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pad_ff <= '0;
    end else begin
      pad_ff <= nxt_pad;
    end
  end

  assign pad = pad_ff;

endmodule

// >>> ppo_pin_sync.sv
// three-stage synchroniser for one pad input with agreement filter
// assumes the input is asynchronous to ref_clk
`timescale 1ns/1ns
module ppo_pin_sync (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic async_in,
  output logic sync_out
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic sync_out_ff;

  // chain of three flops, first read only by the second
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // accept a new level only once stages two and three agree
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_out_ff <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      sync_out_ff <= s3_ff;
    end
  end

  assign sync_out = sync_out_ff;

endmodule

// >>> ppo_pkg.sv
// shared constants and types of the port pin override block
// assumes a single clock domain and an avalon-mm register slave
package ppo_pkg;

  // register bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [4:0] OFF_DIR = 5'h00;
  localparam logic [4:0] OFF_OUTVAL = 5'h04;
  localparam logic [4:0] OFF_INPUT = 5'h08;
  localparam logic [4:0] OFF_CTRL = 5'h0C;
  localparam logic [4:0] OFF_EXT_SEL = 5'h10;
  localparam logic [4:0] OFF_EXT_EN = 5'h14;
  localparam logic [4:0] OFF_EXT_EDGE = 5'h18;
  localparam logic [4:0] OFF_EXT_FLAG = 5'h1C;

  // field positions in the control register
  localparam int CTRL_GPUD_BIT = 0;

  // reset values
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_OUTVAL = 8'h00;
  localparam logic [7:0] RST_EXT = 8'h00;
  localparam logic RST_GPUD = 1'b0;

  // pin input synchroniser depth
  localparam int SYNC_STAGES = 3;

  // override bundle that an alternate function drives for one pin
  typedef struct packed {
    logic pullup_override_en;
    logic pullup_override_val;
    logic dir_override_en;
    logic dir_override_val;
    logic value_override_en;
    logic value_override_val;
    logic toggle_override_en;
    logic input_en_override_en;
    logic input_en_override_val;
  } ppo_ovr_t;

  // pad drive bundle for one pin
  typedef struct packed {
    logic oe;
    logic out;
    logic pullup_en;
  } ppo_pad_t;

  // bus handshake states, gray along idle -> ack
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } ppo_bus_state_t;

endpackage

// >>> ppo_port.sv
// top of the port pin override block: avalon-mm registers, per-pin
// override cells, input clamp and synchronisers, external interrupt flags
// assumes sleep_clamp and override bundles come from ref_clk logic and
// pad_in comes straight from the pads
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ns

// Overview of operation
// - clamp digital input low while sleep clamp asserted
// - enabled external interrupt pins escape the clamp
// - edge-sense interrupt pin high sets flag on wake
// - all pull-ups off while reset active
// - pull-up override enable selects override value
// - otherwise pull-up on when dir,val,disable = 010
// - direction override enable selects override value
// - otherwise driver enable follows direction bit
// - value override drives pin when enabled
// - otherwise pin driven from output-value bit
// - toggle override inverts output-value bit
// - input-enable override selects override value
// - otherwise input enable from sleep state
// - raw input after clamp goes to alternate functions
// - analog link wired straight to pad
// - direction one is output, zero is input
// - writing one to input register toggles output value
// - global pull-up disable kills normal pull-ups
// - pin level passes synchroniser before input register
module ppo_port #(
  parameter int NPINS = 8,
  parameter logic [7:0] ALT_PRESENT = 8'hFF
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sleep_clamp,
  input wire ppo_pkg::ppo_ovr_t [NPINS-1:0] alt_ovr,
  input wire logic [NPINS-1:0] pad_in,
  output logic [NPINS-1:0] pad_out,
  output logic [NPINS-1:0] pad_oe,
  output logic [NPINS-1:0] pad_pullup_en,
  output logic [NPINS-1:0] raw_digital_in,
  output logic [NPINS-1:0] analog_pad_link_in,
  input wire logic [NPINS-1:0] analog_pad_link_out,
  input wire logic [NPINS-1:0] analog_pad_link_oe,
  output logic [NPINS-1:0] pad_analog_out,
  output logic [NPINS-1:0] pad_analog_oe
);

  // refuse widths that do not fit the low byte lane
  if (NPINS < 1 || NPINS > 8) begin : g_bad_npins
    $error("NPINS must lie between 1 and 8");
  end

  // address match, used by both write and read decode
  function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] off);
    addr_hit = (addr == off);
  endfunction

  ppo_pkg::ppo_bus_state_t bus_state_ff;
  ppo_pkg::ppo_bus_state_t nxt_bus_state;
  logic waitrequest_ff;
  logic [31:0] readdata_ff;
  logic [31:0] nxt_readdata;
  logic wr_take;

  logic [NPINS-1:0] dir_ff;
  logic [NPINS-1:0] outval_ff;
  logic [NPINS-1:0] nxt_outval;
  logic gpud_ff;
  logic [NPINS-1:0] ext_sel_ff;
  logic [NPINS-1:0] ext_en_ff;
  logic [NPINS-1:0] ext_edge_ff;
  logic [NPINS-1:0] ext_flag_ff;
  logic [NPINS-1:0] nxt_ext_flag;

  logic [NPINS-1:0] pin_sync;
  logic [NPINS-1:0] pin_prev_ff;
  logic [NPINS-1:0] input_en;
  logic [NPINS-1:0] ext_int_active;
  logic [NPINS-1:0] toggle_req;
  logic [NPINS-1:0] wdata_pins;
  logic [NPINS-1:0] pad_out_w;
  logic [NPINS-1:0] pad_oe_w;
  logic [NPINS-1:0] pad_pu_w;
  ppo_pkg::ppo_ovr_t [NPINS-1:0] ovr_eff;

  assign wdata_pins = avs_writedata[NPINS-1:0];

  // bus handshake: one wait cycle, then accept with waitrequest low
  always_comb begin
    nxt_bus_state = ppo_pkg::BUS_IDLE;
    case (bus_state_ff)
      ppo_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_bus_state = ppo_pkg::BUS_ACK;
        end
      end
      ppo_pkg::BUS_ACK: begin
        nxt_bus_state = ppo_pkg::BUS_IDLE;
      end
      default: begin
        nxt_bus_state = ppo_pkg::BUS_IDLE;
      end
    endcase
  end

  // bus state and registered waitrequest
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_state_ff <= ppo_pkg::BUS_IDLE;
      waitrequest_ff <= 1'b1;
    end else begin
      bus_state_ff <= nxt_bus_state;
      waitrequest_ff <= (nxt_bus_state != ppo_pkg::BUS_ACK);
    end
  end

  // a write with byte lane 0 enabled takes effect on the edge where waitrequest is sampled low
  assign wr_take = avs_write && !waitrequest_ff && avs_byteenable[0];

  // read mux, unmapped offsets read zero
  always_comb begin
    nxt_readdata = 32'h0000_0000;
    if (addr_hit(avs_address, ppo_pkg::OFF_DIR)) begin
      nxt_readdata[NPINS-1:0] = dir_ff;
    end else if (addr_hit(avs_address, ppo_pkg::OFF_OUTVAL)) begin
      nxt_readdata[NPINS-1:0] = outval_ff;
    end else if (addr_hit(avs_address, ppo_pkg::OFF_INPUT)) begin
      nxt_readdata[NPINS-1:0] = pin_sync;
    end else if (addr_hit(avs_address, ppo_pkg::OFF_CTRL)) begin
      nxt_readdata[ppo_pkg::CTRL_GPUD_BIT] = gpud_ff;
    end else if (addr_hit(avs_address, ppo_pkg::OFF_EXT_SEL)) begin
      nxt_readdata[NPINS-1:0] = ext_sel_ff;
    end else if (addr_hit(avs_address, ppo_pkg::OFF_EXT_EN)) begin
      nxt_readdata[NPINS-1:0] = ext_en_ff;
    end else if (addr_hit(avs_address, ppo_pkg::OFF_EXT_EDGE)) begin
      nxt_readdata[NPINS-1:0] = ext_edge_ff;
    end else if (addr_hit(avs_address, ppo_pkg::OFF_EXT_FLAG)) begin
      nxt_readdata[NPINS-1:0] = ext_flag_ff;
    end
  end

  // read data captured while the request waits, stands at the accept edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata_ff <= 32'h0000_0000;
    end else if (avs_read && waitrequest_ff) begin
      readdata_ff <= nxt_readdata;
    end
  end

  // direction register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_ff <= ppo_pkg::RST_DIR[NPINS-1:0];
    end else if (wr_take && addr_hit(avs_address, ppo_pkg::OFF_DIR)) begin
      dir_ff <= wdata_pins;
    end
  end

  // toggle sources: input-register write of ones and toggle override
  always_comb begin
    toggle_req = '0;
    if (wr_take && addr_hit(avs_address, ppo_pkg::OFF_INPUT)) begin
      toggle_req = wdata_pins;
    end
    for (int i = 0; i < NPINS; i++) begin
      toggle_req[i] = toggle_req[i] ^ ovr_eff[i].toggle_override_en;
    end
  end

  // output-value register: write first, then any toggle applied
  always_comb begin
    nxt_outval = outval_ff;
    if (wr_take && addr_hit(avs_address, ppo_pkg::OFF_OUTVAL)) begin
      nxt_outval = wdata_pins;
    end
    nxt_outval = nxt_outval ^ toggle_req;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      outval_ff <= ppo_pkg::RST_OUTVAL[NPINS-1:0];
    end else begin
      outval_ff <= nxt_outval;
    end
  end

  // control register holding the global pull-up disable
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gpud_ff <= ppo_pkg::RST_GPUD;
    end else if (wr_take && addr_hit(avs_address, ppo_pkg::OFF_CTRL)) begin
      gpud_ff <= avs_writedata[ppo_pkg::CTRL_GPUD_BIT];
    end
  end

  // external interrupt configuration registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_sel_ff <= ppo_pkg::RST_EXT[NPINS-1:0];
      ext_en_ff <= ppo_pkg::RST_EXT[NPINS-1:0];
      ext_edge_ff <= ppo_pkg::RST_EXT[NPINS-1:0];
    end else if (wr_take) begin
      if (addr_hit(avs_address, ppo_pkg::OFF_EXT_SEL)) begin
        ext_sel_ff <= wdata_pins;
      end else if (addr_hit(avs_address, ppo_pkg::OFF_EXT_EN)) begin
        ext_en_ff <= wdata_pins;
      end else if (addr_hit(avs_address, ppo_pkg::OFF_EXT_EDGE)) begin
        ext_edge_ff <= wdata_pins;
      end
    end
  end

  // besides input-enable overrides, only enabled external interrupt pins escape the sleep clamp
  assign ext_int_active = ext_sel_ff & ext_en_ff;

  // pins without an alternate function see all overrides low
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      ovr_eff[i] = ALT_PRESENT[i] ? alt_ovr[i] : '0;
    end
  end

  // per-pin cells, clamp gate, synchroniser and analog pass-through
  for (genvar g = 0; g < NPINS; g++) begin : g_pin
    ppo_pkg::ppo_pad_t pad_w;

    ppo_pin_cell u_cell (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .dir_bit(dir_ff[g]),
      .outval_bit(outval_ff[g]),
      .global_pullup_disable(gpud_ff),
      .sleep_clamp(sleep_clamp),
      .ext_int_active(ext_int_active[g]),
      .ovr(ovr_eff[g]),
      .input_en(input_en[g]),
      .pad(pad_w)
    );

    assign pad_oe_w[g] = pad_w.oe;
    assign pad_out_w[g] = pad_w.out;
    assign pad_pu_w[g] = pad_w.pullup_en;

    // clamp to ground ahead of the schmitt stage
    assign raw_digital_in[g] = pad_in[g] & input_en[g];

    ppo_pin_sync u_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .async_in(raw_digital_in[g]),
      .sync_out(pin_sync[g])
    );

    // analog link bypasses all digital circuitry
    assign analog_pad_link_in[g] = pad_in[g];
    assign pad_analog_out[g] = analog_pad_link_out[g];
    assign pad_analog_oe[g] = analog_pad_link_oe[g];
  end

  // previous synchronised level for change detection
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_prev_ff <= '0;
    end else begin
      pin_prev_ff <= pin_sync;
    end
  end

  // edge-sense pins flag any change, even with the request disabled,
  // so the clamp release on wake sets the flag; set wins over clear
  always_comb begin
    nxt_ext_flag = ext_flag_ff;
    if (wr_take && addr_hit(avs_address, ppo_pkg::OFF_EXT_FLAG)) begin
      nxt_ext_flag = ext_flag_ff & ~wdata_pins;
    end
    nxt_ext_flag = nxt_ext_flag | (ext_sel_ff & ext_edge_ff & (pin_sync ^ pin_prev_ff));
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_flag_ff <= '0;
    end else begin
      ext_flag_ff <= nxt_ext_flag;
    end
  end

  assign avs_readdata = readdata_ff;
  assign avs_waitrequest = waitrequest_ff;
  assign pad_out = pad_out_w;
  assign pad_oe = pad_oe_w;
  assign pad_pullup_en = pad_pu_w;

endmodule

// >>> ppo_port_chk.sv
// assertion checker for the port pin override top
// assumes it is bound to ppo_port and sees only its ports
`timescale 1ns/1ns
module ppo_port_chk #(
  parameter int NPINS = 8,
  parameter logic [7:0] ALT_PRESENT = 8'hFF
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic sleep_clamp,
  input wire ppo_pkg::ppo_ovr_t [NPINS-1:0] alt_ovr,
  input wire logic [NPINS-1:0] pad_in,
  input wire logic [NPINS-1:0] pad_out,
  input wire logic [NPINS-1:0] pad_oe,
  input wire logic [NPINS-1:0] pad_pullup_en,
  input wire logic [NPINS-1:0] raw_digital_in,
  input wire logic [NPINS-1:0] analog_pad_link_in,
  input wire logic [NPINS-1:0] analog_pad_link_out,
  input wire logic [NPINS-1:0] analog_pad_link_oe,
  input wire logic [NPINS-1:0] pad_analog_out,
  input wire logic [NPINS-1:0] pad_analog_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // bus handshake: one wait cycle, one ack cycle, ack only for a request
  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("request not answered");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("ack longer than a cycle");
  property p_wait_cause;
    $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("ack without request");

  // per-pin checks, override relations only where an alternate function exists
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    if (ALT_PRESENT[i]) begin : g_alt
      property p_dir_ovr;
        alt_ovr[i].dir_override_en |=> pad_oe[i] == $past(alt_ovr[i].dir_override_val);
      endproperty
      a_dir_ovr: assert property (p_dir_ovr) else $error("driver enable override lost");
      property p_pu_ovr;
        alt_ovr[i].pullup_override_en
          |=> pad_pullup_en[i] == $past(alt_ovr[i].pullup_override_val);
      endproperty
      a_pu_ovr: assert property (p_pu_ovr) else $error("pull-up override lost");
      property p_val_ovr;
        alt_ovr[i].value_override_en && alt_ovr[i].dir_override_en
          && alt_ovr[i].dir_override_val
          |=> pad_out[i] == $past(alt_ovr[i].value_override_val);
      endproperty
      a_val_ovr: assert property (p_val_ovr) else $error("value override lost");
      property p_in_ovr;
        alt_ovr[i].input_en_override_en
          |-> raw_digital_in[i] == (pad_in[i] & alt_ovr[i].input_en_override_val);
      endproperty
      a_in_ovr: assert property (p_in_ovr) else $error("input enable override lost");
    end
    property p_in_awake;
      !sleep_clamp && !alt_ovr[i].input_en_override_en |-> raw_digital_in[i] == pad_in[i];
    endproperty
    a_in_awake: assert property (p_in_awake) else $error("raw input blocked awake");
    property p_analog;
      analog_pad_link_in[i] == pad_in[i] && pad_analog_oe[i] == analog_pad_link_oe[i]
        && pad_analog_out[i] == analog_pad_link_out[i];
    endproperty
    a_analog: assert property (p_analog) else $error("analog link not straight");
  end

  // main scenarios reached
  c_sleep: cover property (sleep_clamp && raw_digital_in != '0);
  c_tog: cover property (alt_ovr[3].toggle_override_en);
  c_ack: cover property (!avs_waitrequest && avs_write);
endmodule

bind ppo_port ppo_port_chk #(.NPINS(NPINS), .ALT_PRESENT(ALT_PRESENT)) u_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .sleep_clamp(sleep_clamp), .alt_ovr(alt_ovr),
  .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
  .raw_digital_in(raw_digital_in), .analog_pad_link_in(analog_pad_link_in),
  .analog_pad_link_out(analog_pad_link_out), .analog_pad_link_oe(analog_pad_link_oe),
  .pad_analog_out(pad_analog_out), .pad_analog_oe(pad_analog_oe));

// >>> ppo_port_tb.sv
// self-checking bench for the port pin override top
// assumes the checker is bound in and the peripheral model drives overrides
`timescale 1ns/1ns
module ppo_port_tb;
  localparam int NP = 8;
  logic ref_clk, reset_n, avs_read, avs_write, avs_waitrequest, sleep_clamp, gpud;
  logic [4:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  ppo_pkg::ppo_ovr_t [NP-1:0] req_ovr, alt_ovr;
  logic [NP-1:0] pad_in, pad_out, pad_oe, pad_pu, raw_di, an_in, an_rout, an_roe, an_out;
  logic [NP-1:0] an_oe, pad_an_out, pad_an_oe, di_sync, ext_lvl, ext_en, dir, val, r;
  logic [2:0] e;
  int error_cnt, cmp_count;

  // pad wire: port driver, else outside driver, else pull-up, else pull-down
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_lvl) | (~pad_oe & ~ext_en & pad_pu);

  ppo_port #(.NPINS(NP), .ALT_PRESENT(8'hFF)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sleep_clamp(sleep_clamp), .alt_ovr(alt_ovr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup_en(pad_pu), .raw_digital_in(raw_di),
    .analog_pad_link_in(an_in), .analog_pad_link_out(an_out), .analog_pad_link_oe(an_oe),
    .pad_analog_out(pad_an_out), .pad_analog_oe(pad_an_oe));
  ppo_alt_model #(.NPINS(NP), .ALT_PRESENT(8'hFF)) u_alt (
    .ref_clk(ref_clk), .reset_n(reset_n), .req_ovr(req_ovr), .req_an_out(an_rout),
    .req_an_oe(an_roe), .raw_digital_in(raw_di), .alt_ovr(alt_ovr), .an_out(an_out),
    .an_oe(an_oe), .di_sync(di_sync));

  // clock at 125 MHz
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one avalon transfer, entered just after an edge; idles one cycle after
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    chk(32'(n < 50), 32'h1, "bus answer");
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0, 4'h1);
    chk(rd, exp, what);
  endtask

  // expected {driver enable, value, pull-up} of one pin
  function automatic logic [2:0] exp_pin(input logic d, input logic v, input logic g,
                                         input ppo_pkg::ppo_ovr_t o);
    exp_pin[2] = o.dir_override_en ? o.dir_override_val : d;
    exp_pin[1] = o.value_override_en ? o.value_override_val : v;
    exp_pin[0] = o.pullup_override_en ? o.pullup_override_val : (!d && v && !g);
  endfunction

  // watchdog
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end

  // main sequence
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    {reset_n, avs_read, avs_write, sleep_clamp} = 4'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    req_ovr = '0;
    {an_rout, an_roe, ext_lvl, ext_en} = '0;
    void'($urandom(32'h08b7a128));
    repeat (6) @(posedge ref_clk);
    chk(32'({pad_pu, pad_oe}), 32'h0, "pads in reset");
    reset_n <= 1'b1;
    @(posedge ref_clk);
    // random registers and overrides, plain pins first
    for (int k = 0; k < 40; k++) begin
      {dir, val, gpud} = 17'($urandom);
      for (int i = 0; i < NP; i++) begin
        req_ovr[i] <= (k < 4) ? '0 : ppo_pkg::ppo_ovr_t'(9'($urandom) & 9'h1FB);
      end
      {an_rout, an_roe, ext_en, ext_lvl} <= 32'($urandom);
      wr(ppo_pkg::OFF_DIR, 32'(dir));
      wr(ppo_pkg::OFF_OUTVAL, 32'(val));
      wr(ppo_pkg::OFF_CTRL, 32'(gpud) << ppo_pkg::CTRL_GPUD_BIT);
      repeat (3) @(posedge ref_clk);
      for (int i = 0; i < NP; i++) begin
        e = exp_pin(dir[i], val[i], gpud, req_ovr[i]);
        chk(32'({pad_oe[i], e[2] & pad_out[i], pad_pu[i]}), 32'({e[2], e[2] & e[1], e[0]}),
            "pin drive");
      end
      chk(32'({pad_an_out, pad_an_oe, an_in}), 32'({an_out, an_oe, pad_in}), "analog link");
      rdc(ppo_pkg::OFF_DIR, 32'(dir), "dir readback");
    end
    // toggle by input register, by override pulse, refused write, unmapped read
    req_ovr <= '0;
    wr(ppo_pkg::OFF_OUTVAL, 32'h5A);
    wr(ppo_pkg::OFF_INPUT, 32'h0F);
    rdc(ppo_pkg::OFF_OUTVAL, 32'h55, "toggle by write");
    req_ovr[3].toggle_override_en <= 1'b1;
    @(posedge ref_clk);
    req_ovr[3].toggle_override_en <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rdc(ppo_pkg::OFF_OUTVAL, 32'h5D, "toggle override");
    bus(1'b1, ppo_pkg::OFF_OUTVAL, 32'h0, 4'h0);
    rdc(ppo_pkg::OFF_OUTVAL, 32'h5D, "byteenable off");
    rdc(5'h02, 32'h0, "unmapped read");
    // input path through synchronisers
    wr(ppo_pkg::OFF_DIR, 32'h0);
    r = 8'($urandom);
    ext_en <= 8'hFF;
    ext_lvl <= r;
    repeat (6) @(posedge ref_clk);
    chk(32'(raw_di), 32'(r), "raw input");
    chk(32'(di_sync), 32'(r), "peripheral sync");
    rdc(ppo_pkg::OFF_INPUT, 32'(r), "input register");
    // sleep clamp, interrupt pins and input enable overrides
    ext_lvl <= 8'hFF;
    req_ovr[6].input_en_override_en <= 1'b1;
    req_ovr[6].input_en_override_val <= 1'b1;
    req_ovr[7].input_en_override_en <= 1'b1;
    wr(ppo_pkg::OFF_EXT_SEL, 32'h24);
    wr(ppo_pkg::OFF_EXT_EN, 32'h04);
    wr(ppo_pkg::OFF_EXT_EDGE, 32'h20);
    chk(32'(raw_di), 32'h7F, "awake inputs");
    sleep_clamp <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(32'(raw_di), 32'h44, "clamped inputs");
    wr(ppo_pkg::OFF_EXT_FLAG, 32'hFF);
    bus(1'b0, ppo_pkg::OFF_EXT_FLAG, 32'h0, 4'h1);
    chk(rd & 32'h20, 32'h0, "flag cleared");
    sleep_clamp <= 1'b0;
    repeat (8) @(posedge ref_clk);
    bus(1'b0, ppo_pkg::OFF_EXT_FLAG, 32'h0, 4'h1);
    chk(rd & 32'h20, 32'h20, "flag on wake");
    // pull-ups on, then a second reset in mid-run
    {req_ovr, ext_en} <= '0;
    wr(ppo_pkg::OFF_OUTVAL, 32'hFF);
    wr(ppo_pkg::OFF_CTRL, 32'h0);
    @(posedge ref_clk); // pad register lags the control write by one edge
    chk(32'(pad_pu), 32'hFF, "pull-ups on");
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(32'({pad_pu, pad_oe}), 32'h0, "pads in reset");
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rdc(ppo_pkg::OFF_OUTVAL, 32'h0, "outval reset");
    stop_test();
  end
endmodule
